//--- logic/pmw_pkg.sv
package pmw_pkg;
   // clock period in ns
   localparam int CLK_PERIOD_NS = 10;

   // register indices on the plain register port
   localparam logic [3:0] ADDR_SYSCLK_CTRL = 4'h0;
   localparam logic [3:0] ADDR_RC_HF_CTRL = 4'h1;
   localparam logic [3:0] ADDR_XT_HF_CTRL = 4'h2;
   localparam logic [3:0] ADDR_XT_LF_CTRL = 4'h3;
   localparam logic [3:0] ADDR_PORTA_WAKE = 4'h4;
   localparam logic [3:0] ADDR_WDT_CTRL = 4'h5;
   localparam logic [3:0] ADDR_STATUS = 4'h6;

   // system_clock_ctrl field positions
   localparam int SEL_LSB = 5;
   localparam int HF_SRC_BIT = 3;
   localparam int LF_SRC_BIT = 2;
   localparam int HF_KEEP_BIT = 1;
   localparam int LF_KEEP_BIT = 0;
   localparam logic [7:0] SYSCLK_CTRL_MASK = 8'hef;
   localparam logic [2:0] SEL_LF = 3'h7;

   // oscillator control layout: enable bit 0, stable flag bit 1
   localparam int OSC_EN_BIT = 0;
   localparam int OSC_FLAG_BIT = 1;

   // status layout
   localparam int ST_PWRDN_BIT = 0;
   localparam int ST_TIMEOUT_BIT = 1;
   localparam int ST_SLOW_BIT = 2;
   localparam int ST_MODE_LSB = 3;

   // values after reset
   localparam logic [7:0] RST_SYSCLK_CTRL = 8'h00;
   localparam logic RST_RC_HF_EN = 1'b1;
   localparam logic RST_XT_HF_EN = 1'b0;
   localparam logic RST_XT_LF_EN = 1'b0;
   localparam logic [7:0] RST_PORTA_WAKE = 8'h00;
   localparam logic RST_WDT_EN = 1'b1;

   // oscillator index: 0 rc hf, 1 crystal hf, 2 crystal lf, 3 rc lf
   localparam int NUM_OSC = 4;
   localparam int OSC_RC_HF_START_NS = 2000;
   localparam int OSC_XT_HF_START_NS = 5000;
   localparam int OSC_XT_LF_START_NS = 8000;
   localparam int OSC_RC_LF_START_NS = 1000;
   localparam logic [11:0] OSC_START_CYC [NUM_OSC] = '{
      12'((OSC_RC_HF_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS),
      12'((OSC_XT_HF_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS),
      12'((OSC_XT_LF_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS),
      12'((OSC_RC_LF_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS)};

   // sequencer states, gray along active, low power, wake, resume
   typedef enum logic [1:0] {
      PMW_ACTIVE = 2'h0,
      PMW_LOWPWR = 2'h1,
      PMW_WAKE = 2'h3,
      PMW_RESUME = 2'h2
   } pmw_state_t;

   // low power mode, coded as {hf keep, lf keep}
   typedef enum logic [1:0] {
      PMW_SLEEP = 2'h0,
      PMW_IDLE_LF_ONLY = 2'h1,
      PMW_IDLE_HF_ONLY = 2'h2,
      PMW_IDLE_BOTH_CLOCKS = 2'h3
   } pmw_lpmode_t;
endpackage

//--- logic/pmw_osc_settle.sv
`timescale 1ns/10ps
module pmw_osc_settle #(
   parameter logic [11:0] SETTLE_CYC = 12'h001
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic osc_en,
   output logic stable_q
);
   logic [11:0] cnt_q;

   // flag drops while off, rises once the start-up count has elapsed
   always_ff @(posedge core_clk) begin
      if (rst || !osc_en) begin
         cnt_q <= 12'h000;
         stable_q <= 1'b0;
      end else if (cnt_q >= SETTLE_CYC - 12'h001) begin
         stable_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 12'h001;
      end
   end
endmodule // pmw_osc_settle

//--- logic/pmw_power_ctrl.sv
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/10ps
// What this block does
// - code 111 moves system clock to slow
// - slow source picked by select bit, waits stable
// - codes 000-110 give normal, hf divided 1..64
// - halt with both keeps clear enters sleep
// - halt, lf keep only: idle lf only
// - halt, both keeps: idle both clocks
// - halt, hf keep only: idle hf only
// - low power keeps memory, registers, ports
// - halt sets power-down, clears time-out flag
// - halt clears watchdog; runs only if enabled
// - wake on port a fall, interrupt, watchdog
// - power-up or clear-watchdog clears power-down flag
// - watchdog wake sets time-out, resets pc/sp
// - each port a pin has wake enable
// - port a wake resumes after halt
// - disabled or stack-full interrupt resumes after halt
// - enabled interrupt with stack room gets serviced
// - flags set before halt do not wake
// - wake waits for system oscillator stable
// - stable flag clears then sets once stable
// - rc lf runs whenever watchdog enabled
module pmw_power_ctrl (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic halt_strobe,
   input wire logic clr_wdt_strobe,
   input wire logic [7:0] porta_pins,
   input wire logic [7:0] int_req_flags,
   input wire logic [7:0] int_enable,
   input wire logic stack_full,
   input wire logic wdt_overflow,
   output logic sysclk_from_lf,
   output logic [2:0] sysclk_div_log2,
   output logic cpu_run,
   output logic state_hold,
   output logic hf_clk_on,
   output logic lf_clk_on,
   output logic [3:0] osc_enable,
   output logic wdt_run,
   output logic wdt_clear,
   output logic wake_resume_next,
   output logic wake_int_service,
   output logic pc_sp_reset,
   output logic wdt_chip_reset,
   output logic power_down_flag,
   output logic watchdog_timeout_flag
);
   pmw_pkg::pmw_state_t state_q;
   pmw_pkg::pmw_state_t state_d;
   pmw_pkg::pmw_lpmode_t lp_mode_q;
   logic [7:0] system_clock_ctrl_q;
   logic rc_hf_en_q;
   logic xt_hf_en_q;
   logic xt_lf_en_q;
   logic [7:0] porta_wake_enable_q;
   logic wdt_en_q;
   logic [7:0] porta_prev_q;
   logic [7:0] int_mask_q;
   logic [7:0] int_src_q;
   logic cause_port_q;
   logic cause_int_q;
   logic cause_wdt_q;
   logic [3:0] osc_stable;
   logic [2:0] sysclk_select;
   logic lf_source_select;
   logic hf_osc_keep_on_halt;
   logic lf_osc_keep_on_halt;
   logic run_hf;
   logic run_lf;
   logic hf_stable;
   logic lf_stable;
   logic sys_src_stable;
   logic halt_taken;
   logic [7:0] port_fall;
   logic [7:0] int_new;
   logic wake_any;
   logic [7:0] rd_mux;

   // control fields
   assign sysclk_select = system_clock_ctrl_q[pmw_pkg::SEL_LSB +: 3];
   assign lf_source_select = system_clock_ctrl_q[pmw_pkg::LF_SRC_BIT];
   assign hf_osc_keep_on_halt = system_clock_ctrl_q[pmw_pkg::HF_KEEP_BIT];
   assign lf_osc_keep_on_halt = system_clock_ctrl_q[pmw_pkg::LF_KEEP_BIT];
   assign halt_taken = (state_q == pmw_pkg::PMW_ACTIVE) && halt_strobe;

   // register writes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         system_clock_ctrl_q <= pmw_pkg::RST_SYSCLK_CTRL;
         rc_hf_en_q <= pmw_pkg::RST_RC_HF_EN;
         xt_hf_en_q <= pmw_pkg::RST_XT_HF_EN;
         xt_lf_en_q <= pmw_pkg::RST_XT_LF_EN;
         porta_wake_enable_q <= pmw_pkg::RST_PORTA_WAKE;
         wdt_en_q <= pmw_pkg::RST_WDT_EN;
      end else if (reg_wr) begin
         case (reg_addr)
            pmw_pkg::ADDR_SYSCLK_CTRL: begin
               system_clock_ctrl_q <= reg_wdata & pmw_pkg::SYSCLK_CTRL_MASK;
            end
            pmw_pkg::ADDR_RC_HF_CTRL: rc_hf_en_q <= reg_wdata[pmw_pkg::OSC_EN_BIT];
            pmw_pkg::ADDR_XT_HF_CTRL: xt_hf_en_q <= reg_wdata[pmw_pkg::OSC_EN_BIT];
            pmw_pkg::ADDR_XT_LF_CTRL: xt_lf_en_q <= reg_wdata[pmw_pkg::OSC_EN_BIT];
            pmw_pkg::ADDR_PORTA_WAKE: porta_wake_enable_q <= reg_wdata;
            pmw_pkg::ADDR_WDT_CTRL: wdt_en_q <= reg_wdata[0];
            default: begin
            end
         endcase
      end
   end

   // read mux, unmapped reads zero
   always_comb begin
      rd_mux = 8'h00;
      case (reg_addr)
         pmw_pkg::ADDR_SYSCLK_CTRL: rd_mux = system_clock_ctrl_q;
         pmw_pkg::ADDR_RC_HF_CTRL: rd_mux = {6'h00, osc_stable[0], rc_hf_en_q};
         pmw_pkg::ADDR_XT_HF_CTRL: rd_mux = {6'h00, osc_stable[1], xt_hf_en_q};
         pmw_pkg::ADDR_XT_LF_CTRL: rd_mux = {6'h00, osc_stable[2], xt_lf_en_q};
         pmw_pkg::ADDR_PORTA_WAKE: rd_mux = porta_wake_enable_q;
         pmw_pkg::ADDR_WDT_CTRL: rd_mux = {7'h00, wdt_en_q};
         pmw_pkg::ADDR_STATUS: begin
            rd_mux = {3'h0, lp_mode_q, sysclk_from_lf, watchdog_timeout_flag,
                      power_down_flag};
         end
         default: rd_mux = 8'h00;
      endcase
   end

   // read data valid in the cycle after the strobe only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // oscillator requests per mode
   assign run_hf = (state_q != pmw_pkg::PMW_LOWPWR) || lp_mode_q[1];
   assign run_lf = (state_q != pmw_pkg::PMW_LOWPWR) || lp_mode_q[0];
   assign osc_enable[0] = rc_hf_en_q && run_hf;
   assign osc_enable[1] = xt_hf_en_q && run_hf;
   assign osc_enable[2] = xt_lf_en_q && run_lf && lf_source_select;
   assign osc_enable[3] = (run_lf && !lf_source_select) || wdt_en_q;

   // start-up timers, one per oscillator
   genvar gi;
   generate
      for (gi = 0; gi < pmw_pkg::NUM_OSC; gi = gi + 1) begin : g_osc
         pmw_osc_settle #(
            .SETTLE_CYC(pmw_pkg::OSC_START_CYC[gi])
         ) u_settle (
            .core_clk(core_clk),
            .rst(rst),
            .osc_en(osc_enable[gi]),
            .stable_q(osc_stable[gi])
         );
      end
   endgenerate

   // stable status of the chosen sources
   assign hf_stable = system_clock_ctrl_q[pmw_pkg::HF_SRC_BIT] ? osc_stable[1] : osc_stable[0];
   assign lf_stable = lf_source_select ? osc_stable[2] : osc_stable[3];
   assign sys_src_stable = sysclk_from_lf ? lf_stable : hf_stable;
   assign hf_clk_on = run_hf;
   assign lf_clk_on = run_lf;

   // system clock source and divider
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sysclk_from_lf <= 1'b0;
         sysclk_div_log2 <= 3'h0;
      end else if (sysclk_select != pmw_pkg::SEL_LF) begin
         sysclk_from_lf <= 1'b0;
         sysclk_div_log2 <= sysclk_select;
      end else if (lf_stable) begin
         sysclk_from_lf <= 1'b1;
      end
   end

   // wake sources
   assign port_fall = porta_prev_q & ~porta_pins & porta_wake_enable_q;
   assign int_new = int_req_flags & ~int_mask_q;
   assign wake_any = (|port_fall) || (|int_new) || wdt_overflow;

   // port history and pre-halt interrupt snapshot
   always_ff @(posedge core_clk) begin
      if (rst) begin
         porta_prev_q <= 8'h00;
         int_mask_q <= 8'h00;
      end else begin
         porta_prev_q <= porta_pins;
         if (halt_taken) begin
            int_mask_q <= int_req_flags;
         end
      end
   end

   // sequencer next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         pmw_pkg::PMW_ACTIVE: begin
            if (halt_strobe) begin
               state_d = pmw_pkg::PMW_LOWPWR;
            end
         end
         pmw_pkg::PMW_LOWPWR: begin
            if (wake_any) begin
               state_d = pmw_pkg::PMW_WAKE;
            end
         end
         pmw_pkg::PMW_WAKE: begin
            if (sys_src_stable) begin
               state_d = pmw_pkg::PMW_RESUME;
            end
         end
         pmw_pkg::PMW_RESUME: state_d = pmw_pkg::PMW_ACTIVE;
         default: state_d = pmw_pkg::PMW_ACTIVE;
      endcase
   end

   // sequencer state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= pmw_pkg::PMW_ACTIVE;
      end else begin
         state_q <= state_d;
      end
   end

   // mode taken from keep bits on the halt strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         lp_mode_q <= pmw_pkg::PMW_SLEEP;
      end else if (halt_taken) begin
         lp_mode_q <= pmw_pkg::pmw_lpmode_t'({hf_osc_keep_on_halt, lf_osc_keep_on_halt});
      end
   end

   // wake cause capture, watchdog first then interrupt then port
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cause_port_q <= 1'b0;
         cause_int_q <= 1'b0;
         cause_wdt_q <= 1'b0;
         int_src_q <= 8'h00;
      end else if (state_q == pmw_pkg::PMW_LOWPWR && wake_any) begin
         cause_wdt_q <= wdt_overflow;
         cause_int_q <= !wdt_overflow && (|int_new);
         cause_port_q <= !wdt_overflow && !(|int_new);
         int_src_q <= int_new;
      end
   end

   // cpu gating: held state, nothing cleared while halted
   assign cpu_run = (state_q == pmw_pkg::PMW_ACTIVE);
   assign state_hold = !cpu_run;
   assign wdt_run = wdt_en_q;

   // one-cycle results on the resume cycle and halt side effects
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wdt_clear <= 1'b0;
         wake_resume_next <= 1'b0;
         wake_int_service <= 1'b0;
         pc_sp_reset <= 1'b0;
         wdt_chip_reset <= 1'b0;
      end else begin
         wdt_clear <= halt_taken || clr_wdt_strobe;
         wdt_chip_reset <= wdt_overflow && state_q == pmw_pkg::PMW_ACTIVE;
         if (state_q == pmw_pkg::PMW_WAKE && sys_src_stable) begin
            pc_sp_reset <= cause_wdt_q;
            wake_int_service <= cause_int_q && (|(int_src_q & int_enable)) && !stack_full;
            wake_resume_next <= cause_port_q ||
                                (cause_int_q && (!(|(int_src_q & int_enable)) || stack_full));
         end else begin
            pc_sp_reset <= 1'b0;
            wake_int_service <= 1'b0;
            wake_resume_next <= 1'b0;
         end
      end
   end

   // power-down flag, halt set wins over clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         power_down_flag <= 1'b0;
      end else if (halt_taken) begin
         power_down_flag <= 1'b1;
      end else if (clr_wdt_strobe) begin
         power_down_flag <= 1'b0;
      end
   end

   // time-out flag, overflow set wins over halt clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         watchdog_timeout_flag <= 1'b0;
      end else if (wdt_overflow && state_q != pmw_pkg::PMW_WAKE) begin
         watchdog_timeout_flag <= 1'b1;
      end else if (halt_taken) begin
         watchdog_timeout_flag <= 1'b0;
      end
   end

   // checks
   localparam int WAKE_MAX = 900;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_halt;
      state_q == pmw_pkg::PMW_ACTIVE && halt_strobe;
   endsequence
   sequence s_wake_done;
      state_q == pmw_pkg::PMW_WAKE && sys_src_stable ##1 state_q == pmw_pkg::PMW_RESUME;
   endsequence

   a_halt_flags: assert property (
      s_halt ##0 !wdt_overflow |=> power_down_flag && !watchdog_timeout_flag && wdt_clear)
      else $error("halt did not set power-down and clear time-out");
   a_halt_mode_pick: assert property (
      s_halt |=> state_q == pmw_pkg::PMW_LOWPWR && lp_mode_q == $past(system_clock_ctrl_q[1:0]))
      else $error("halt mode not taken from keep bits");
   a_lowpwr_clocks: assert property (
      state_q == pmw_pkg::PMW_LOWPWR |-> !cpu_run && hf_clk_on == lp_mode_q[1]
      && lf_clk_on == lp_mode_q[0])
      else $error("low power clocks do not match mode");
   a_clr_pdf: assert property (
      clr_wdt_strobe && !halt_taken |=> !power_down_flag)
      else $error("clear-watchdog left power-down flag set");
   a_slow_entry: assert property (
      sysclk_select == pmw_pkg::SEL_LF && lf_stable |=> sysclk_from_lf)
      else $error("slow mode not entered");
   a_slow_wait: assert property (
      !sysclk_from_lf && !lf_stable |=> !sysclk_from_lf)
      else $error("slow mode entered before oscillator stable");
   a_normal_div: assert property (
      sysclk_select != pmw_pkg::SEL_LF |=> !sysclk_from_lf && sysclk_div_log2 == $past(sysclk_select))
      else $error("normal divider not applied");
   a_stale_int: assert property (
      state_q == pmw_pkg::PMW_LOWPWR && !(|port_fall) && !wdt_overflow && !(|int_new)
      |=> state_q == pmw_pkg::PMW_LOWPWR)
      else $error("woke without a new source");
   a_wdt_wake: assert property (
      state_q == pmw_pkg::PMW_LOWPWR && wdt_overflow
      |=> watchdog_timeout_flag ##[0:WAKE_MAX] pc_sp_reset)
      else $error("watchdog wake did not reset pc and stack");
   a_wake_osc: assert property (
      state_q == pmw_pkg::PMW_WAKE && !sys_src_stable |=> state_q == pmw_pkg::PMW_WAKE)
      else $error("resumed before oscillator stable");
   a_wake_pulse: assert property (
      s_wake_done |-> wake_resume_next || wake_int_service || pc_sp_reset)
      else $error("resume cycle without a wake result");
   a_int_service: assert property (
      wake_int_service |-> !$past(stack_full) && $past(state_q) == pmw_pkg::PMW_WAKE)
      else $error("interrupt serviced with stack full");
   a_rc_lf_osc_wdt: assert property (
      wdt_en_q |-> osc_enable[3])
      else $error("rc lf stopped with watchdog enabled");
endmodule // pmw_power_ctrl

//--- tb/pmw_power_ctrl_tb_top.sv
`timescale 1ns/10ps
module pmw_power_ctrl_tb_top;
   logic core_clk, rst, reg_wr, reg_rd, halt_strobe, clr_wdt_strobe, stack_full, wdt_overflow;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, porta_pins, int_req_flags, int_enable, rv;
   logic sysclk_from_lf, cpu_run, state_hold, hf_clk_on, lf_clk_on, wdt_run, wdt_clear;
   logic wake_resume_next, wake_int_service, pc_sp_reset, wdt_chip_reset;
   logic power_down_flag, watchdog_timeout_flag, hfk, lfk, wen;
   logic [2:0] sysclk_div_log2;
   logic [3:0] osc_enable;
   int error_cnt, num_checks, seed, n, k, i, mdl_pdf, mdl_to;
   int exp_q[$];

   pmw_power_ctrl dut (
      .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_strobe(halt_strobe),
      .clr_wdt_strobe(clr_wdt_strobe), .porta_pins(porta_pins), .int_req_flags(int_req_flags),
      .int_enable(int_enable), .stack_full(stack_full), .wdt_overflow(wdt_overflow),
      .sysclk_from_lf(sysclk_from_lf), .sysclk_div_log2(sysclk_div_log2), .cpu_run(cpu_run),
      .state_hold(state_hold), .hf_clk_on(hf_clk_on), .lf_clk_on(lf_clk_on),
      .osc_enable(osc_enable), .wdt_run(wdt_run), .wdt_clear(wdt_clear),
      .wake_resume_next(wake_resume_next), .wake_int_service(wake_int_service),
      .pc_sp_reset(pc_sp_reset), .wdt_chip_reset(wdt_chip_reset),
      .power_down_flag(power_down_flag), .watchdog_timeout_flag(watchdog_timeout_flag));

   // free running core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // every drive lands just after an edge
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      tick();
      reg_wr <= 1'b0;
      tick();
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      tick();
      reg_rd <= 1'b0;
      d = reg_rdata;
      tick();
   endtask

   // halt strobe and the entry effects seen one cycle later
   task automatic halt();
      halt_strobe <= 1'b1;
      tick();
      halt_strobe <= 1'b0;
      mdl_pdf = 1;
      mdl_to = 0;
      check({7'h0, cpu_run}, 8'h00);
      check({7'h0, state_hold}, 8'h01);
      check({7'h0, power_down_flag}, 8'(mdl_pdf));
      check({7'h0, watchdog_timeout_flag}, 8'(mdl_to));
      check({7'h0, wdt_clear}, 8'h01);
   endtask

   // bounded wait for the resume cycle
   task automatic wait_wake(output int cnt);
      cnt = 0;
      while (!(wake_resume_next === 1'b1 || wake_int_service === 1'b1 ||
               pc_sp_reset === 1'b1) && cnt < 1500) begin
         tick();
         cnt++;
      end
      check({7'h0, cnt < 1500}, 8'h01);
   endtask

   task automatic clr_wdt();
      clr_wdt_strobe <= 1'b1;
      tick();
      clr_wdt_strobe <= 1'b0;
      mdl_pdf = 0;
      check({7'h0, wdt_clear}, 8'h01);
      check({7'h0, power_down_flag}, 8'(mdl_pdf));
   endtask

   // hang guard
   initial begin
      repeat (30000) @(posedge core_clk);
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, 8'h00, 8'h01);
      stop_test();
   end

   initial begin
      seed = 75962;
      rst = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd, halt_strobe, clr_wdt_strobe} = '0;
      {int_req_flags, int_enable, stack_full, wdt_overflow} = '0;
      porta_pins = 8'hff;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      tick();
      // reset values, read-only and unmapped places
      rd(pmw_pkg::ADDR_SYSCLK_CTRL, rv);
      check(rv, pmw_pkg::RST_SYSCLK_CTRL);
      wr(pmw_pkg::ADDR_STATUS, 8'hff);
      rd(pmw_pkg::ADDR_STATUS, rv);
      check(rv, 8'h00);
      wr(4'hf, 8'hff);
      rd(4'hf, rv);
      check(rv, 8'h00);
      // random writes held in the register model, read back in order
      for (i = 0; i < 8; i++) begin
         rv = 8'($random(seed));
         wr(pmw_pkg::ADDR_PORTA_WAKE, rv);
         exp_q.push_back(int'(rv));
         wr(pmw_pkg::ADDR_SYSCLK_CTRL, {3'h0, rv[4:0]});
         exp_q.push_back(int'({3'h0, rv[4:0]} & pmw_pkg::SYSCLK_CTRL_MASK));
         rd(pmw_pkg::ADDR_PORTA_WAKE, rv);
         check(rv, 8'(exp_q.pop_front()));
         rd(pmw_pkg::ADDR_SYSCLK_CTRL, rv);
         check(rv, 8'(exp_q.pop_front()));
      end
      wr(pmw_pkg::ADDR_SYSCLK_CTRL, 8'h00);
      wr(pmw_pkg::ADDR_PORTA_WAKE, 8'h00);
      rd(pmw_pkg::ADDR_RC_HF_CTRL, rv);
      check(rv, 8'h01);
      repeat (250) tick();
      rd(pmw_pkg::ADDR_RC_HF_CTRL, rv);
      check(rv, 8'h03);
      wr(pmw_pkg::ADDR_XT_HF_CTRL, 8'h01);
      rd(pmw_pkg::ADDR_XT_HF_CTRL, rv);
      check(rv, 8'h01);
      repeat (510) tick();
      rd(pmw_pkg::ADDR_XT_HF_CTRL, rv);
      check(rv, 8'h03);
      $display("test reset_and_osc done");
      // every normal divide code, then slow on rc lf
      for (k = 0; k < 8; k++) begin
         wr(pmw_pkg::ADDR_SYSCLK_CTRL, 8'(k << pmw_pkg::SEL_LSB));
         tick();
         check({7'h0, sysclk_from_lf}, {7'h0, k == 7});
         if (k < 7) check({5'h0, sysclk_div_log2}, 8'(k));
      end
      // slow on crystal lf waits for it to settle
      wr(pmw_pkg::ADDR_SYSCLK_CTRL, 8'h00);
      wr(pmw_pkg::ADDR_XT_LF_CTRL, 8'h01);
      wr(pmw_pkg::ADDR_SYSCLK_CTRL, 8'he4);
      tick();
      check({7'h0, sysclk_from_lf}, 8'h00);
      n = 0;
      while (sysclk_from_lf !== 1'b1 && n < 1000) begin
         tick();
         n++;
      end
      check({7'h0, n > 700 && n < 1000}, 8'h01);
      wr(pmw_pkg::ADDR_SYSCLK_CTRL, 8'h00);
      // software looks at the hf stable flag before trusting normal mode
      rd(pmw_pkg::ADDR_RC_HF_CTRL, rv);
      check(rv, 8'h03);
      $display("test clock_select done");
      // every low power mode, woken by a random port pin
      for (i = 0; i < 5; i++) begin
         hfk = (i == 2 || i == 3);
         lfk = (i == 1 || i == 3);
         wen = (i != 4);
         k = $unsigned($random(seed)) % 8;
         wr(pmw_pkg::ADDR_WDT_CTRL, {7'h0, wen});
         wr(pmw_pkg::ADDR_PORTA_WAKE, 8'h01 << k);
         wr(pmw_pkg::ADDR_SYSCLK_CTRL, {4'h0, i == 4, 1'b0, hfk, lfk});
         halt();
         check({7'h0, hf_clk_on}, {7'h0, hfk});
         check({7'h0, lf_clk_on}, {7'h0, lfk});
         check({4'h0, osc_enable}, {4'h0, lfk | wen, 1'b0, hfk, hfk});
         check({7'h0, wdt_run}, {7'h0, wen});
         rd(pmw_pkg::ADDR_STATUS, rv);
         check(rv & 8'h1b, {3'h0, hfk, lfk, 3'h1});
         porta_pins <= 8'hff ^ (8'h01 << ((k + 1) % 8));
         repeat (4) tick();
         check({7'h0, cpu_run}, 8'h00);
         porta_pins <= porta_pins & ~(8'h01 << k);
         wait_wake(n);
         check({7'h0, wake_resume_next}, 8'h01);
         check({7'h0, hfk || n >= (i == 4 ? 500 : 200)}, 8'h01);
         tick();
         porta_pins <= 8'hff;
         check({7'h0, cpu_run}, 8'h01);
         check({7'h0, power_down_flag}, 8'(mdl_pdf));
         clr_wdt();
      end
      wr(pmw_pkg::ADDR_WDT_CTRL, 8'h01);
      wr(pmw_pkg::ADDR_PORTA_WAKE, 8'h00);
      $display("test halt_modes done");
      // interrupt wake: serviced, disabled, stack full
      wr(pmw_pkg::ADDR_SYSCLK_CTRL, 8'h03);
      for (i = 0; i < 3; i++) begin
         int_req_flags <= 8'h01;
         int_enable <= (i == 1) ? 8'h00 : 8'h03;
         stack_full <= (i == 2);
         tick();
         halt();
         repeat (5) tick();
         check({7'h0, cpu_run}, 8'h00);
         int_req_flags <= 8'h03;
         wait_wake(n);
         check({7'h0, wake_int_service}, {7'h0, i == 0});
         check({7'h0, wake_resume_next}, {7'h0, i != 0});
         tick();
         int_req_flags <= 8'h00;
      end
      stack_full <= 1'b0;
      $display("test int_wake done");
      // watchdog overflow in low power and while running
      halt();
      wdt_overflow <= 1'b1;
      tick();
      wdt_overflow <= 1'b0;
      check({7'h0, wdt_chip_reset}, 8'h00);
      wait_wake(n);
      mdl_to = 1;
      check({7'h0, pc_sp_reset}, 8'h01);
      check({7'h0, watchdog_timeout_flag}, 8'(mdl_to));
      check({7'h0, power_down_flag}, 8'(mdl_pdf));
      tick();
      check({7'h0, cpu_run}, 8'h01);
      wdt_overflow <= 1'b1;
      tick();
      wdt_overflow <= 1'b0;
      check({7'h0, wdt_chip_reset}, 8'h01);
      $display("test wdt_wake done");
      stop_test();
   end
endmodule // pmw_power_ctrl_tb_top
